// ### hdl/host_port_pkg.sv
// Constants for the multiplexed host bus port block.
// Assumes an APB master with 32-bit data and one clock for everything.
package host_port_pkg;
  // ----------------------------------------
  // APB register byte addresses
  // ----------------------------------------
  localparam logic [11:0] CONFIG_ADDR  = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] CAPTURE_ADDR = 12'h008;
  localparam logic [11:0] POINTER_ADDR = 12'h00C;

  // ----------------------------------------
  // Config fields
  // ----------------------------------------
  localparam int CFG_MULT0_BIT = 0;
  localparam int CFG_MULT1_BIT = 1;
  localparam int CFG_SLOW_BIT  = 2;
  localparam int CFG_RBT_BIT   = 3;
  localparam int CFG_STYLE_BIT = 4;
  localparam int CFG_W         = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // ----------------------------------------
  // Status fields, write one to clear
  // ----------------------------------------
  localparam int ST_CYCLE_BIT = 0;
  localparam int ST_DPTR_BIT  = 1;
  localparam int ST_LOWWR_BIT = 2;
  localparam int ST_RBT_BIT   = 3;
  localparam int ST_DIR_BIT   = 4;
  localparam int ST_W         = 5;
  localparam logic [ST_W-1:0] ST_RESET = 5'h00;

  // ----------------------------------------
  // Internal host-visible register addresses
  // ----------------------------------------
  localparam logic [2:0] HA_PTR_HIGH = 3'h4;
  localparam logic [2:0] HA_PTR_LOW  = 3'h5;
  localparam logic [2:0] HA_DATA     = 3'h6;
  localparam logic [2:0] HA_SCRATCH_TOP = 3'h3;

  // ----------------------------------------
  // Spacing in arbitration clock periods
  // ----------------------------------------
  localparam logic [2:0] CYCLE_MIN_TARB = 3'h4;
  localparam logic [2:0] DPTR_MIN_TARB  = 3'h5;
  localparam logic [2:0] LOWWR_MIN_TARB = 3'h4;
  localparam logic [2:0] COUNT_SAT      = 3'h7;

  // Operating clock divide per multiplier setting, in clk cycles
  localparam logic [2:0] DIV_MULT0 = 3'h4;
  localparam logic [2:0] DIV_MULT1 = 3'h2;
  localparam logic [2:0] DIV_MULTX = 3'h1;
endpackage

// ### hdl/host_bus_access_spacing.sv
// Multiplexed host bus port with arbitration-clock spacing checks.
// Assumes host pins synchronous to clk; APB slave for configuration.
// Function
// (R01) Host keeps read bus timing select at zero in multiplexed mode.
// (R02) Host spaces strobe leading edges by at least four arbitration periods.
// (R03) Pointer read after data access waits five arbitration periods.
// (R04) Low pointer write after data access waits five arbitration periods.
// (R05) Any strobe after low pointer write waits four arbitration periods.
// (R06) Arbitration period equals operating period, doubled when slow selected.
// (R07) Operating period follows the two clock multiplier bits.
// (R08) Address and chip select captured on address latch falling edge.
// (R09) Write data taken on trailing edge of write or data strobe.
// (R10) Host plans double bus cycle time for back-to-back accesses.
// (R11) Direction line stable from strobe leading edge to trailing edge.
// (R12) Device counts strobe spacing internally in arbitration clock cycles.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module host_bus_access_spacing
  import host_port_pkg::*;
#(
  parameter int PTR_W = 11
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        addressLatch,
  input  wire logic        chip_select_n,
  input  wire logic        data_strobe_n,
  input  wire logic        direction,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  adIn,
  output logic      [7:0]  adOut,
  output logic             adOe
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [CFG_W-1:0] cfg;
  logic [ST_W-1:0]  status;
  logic [2:0]       oprCnt;
  logic             slowPhase;
  logic             aleQ;
  logic [2:0]       capAddr;
  logic             capSel;
  logic             strobeQ;
  logic             readQ;
  logic             dirQ;
  logic [2:0]       sinceLead;
  logic [2:0]       sinceTrail;
  logic             prevData;
  logic             prevLowWr;
  logic [PTR_W-1:0] ptr;
  logic [7:0]       scratch [4];
  logic [7:0]       mem [2**PTR_W];

  function automatic logic [2:0] opr_div(input logic [1:0] mult);
    unique case (mult)
      2'b00:   opr_div = DIV_MULT0;
      2'b01:   opr_div = DIV_MULT1;
      default: opr_div = DIV_MULTX;
    endcase
  endfunction

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic tick);
    sat_inc = (tick && v != COUNT_SAT) ? v + 3'h1 : v;
  endfunction

  // ----------------------------------------
  // Arbitration clock
  // ----------------------------------------
  logic       oprTick;
  logic       arbTick;
  logic [2:0] divNow;
  assign divNow  = opr_div({cfg[CFG_MULT1_BIT], cfg[CFG_MULT0_BIT]});
  assign oprTick = (oprCnt >= divNow - 3'h1);                          // [R07]
  assign arbTick = oprTick && (!cfg[CFG_SLOW_BIT] || slowPhase);       // [R06]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oprCnt    <= 3'h0;
      slowPhase <= 1'b0;
    end else begin
      oprCnt <= oprTick ? 3'h0 : oprCnt + 3'h1;  // [R07]
      if (oprTick)
        slowPhase <= !slowPhase;                  // [R06]
    end
  end

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  logic style68;
  logic strobe;
  logic isRead;
  logic lead;
  logic trail;
  assign style68 = cfg[CFG_STYLE_BIT];
  assign strobe  = style68 ? !data_strobe_n : (!read_strobe_n || !write_strobe_n);
  assign isRead  = style68 ? direction : !read_strobe_n;
  assign lead    = strobe && !strobeQ && capSel;
  assign trail   = !strobe && strobeQ && capSel;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aleQ    <= 1'b0;
      capAddr <= 3'h0;
      capSel  <= 1'b0;
    end else begin
      aleQ <= addressLatch;
      if (aleQ && !addressLatch) begin
        capAddr <= adIn[2:0];                     // [R08]
        capSel  <= !chip_select_n;                // [R08]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobeQ <= 1'b0;
      readQ   <= 1'b0;
      dirQ    <= 1'b0;
    end else begin
      strobeQ <= strobe;
      if (lead) begin
        readQ <= isRead;
        dirQ  <= direction;
      end
    end
  end

  // ----------------------------------------
  // Spacing counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sinceLead  <= COUNT_SAT;
      sinceTrail <= COUNT_SAT;
      prevData   <= 1'b0;
      prevLowWr  <= 1'b0;
    end else begin
      sinceLead  <= lead ? 3'h0 : sat_inc(sinceLead, arbTick);   // [R12]
      sinceTrail <= trail ? 3'h0 : sat_inc(sinceTrail, arbTick); // [R12]
      if (trail) begin
        prevData  <= (capAddr == HA_DATA);
        prevLowWr <= (capAddr == HA_PTR_LOW) && !readQ;
      end
    end
  end

  // ----------------------------------------
  // Violation flags, set wins over clear
  // ----------------------------------------
  logic            ptrTarget;
  logic [ST_W-1:0] setFlags;
  logic [ST_W-1:0] clrFlags;
  logic            apbAccess;
  assign apbAccess = psel && penable && !pready;
  assign ptrTarget = (capAddr == HA_PTR_LOW) || (capAddr == HA_PTR_HIGH);
  always_comb begin
    setFlags = '0;
    setFlags[ST_CYCLE_BIT] = lead && sinceLead < CYCLE_MIN_TARB;                  // [R02]
    setFlags[ST_DPTR_BIT]  = lead && prevData && sinceTrail < DPTR_MIN_TARB
                             && ((ptrTarget && isRead)                            // [R03]
                             || (capAddr == HA_PTR_LOW && !isRead));              // [R04]
    setFlags[ST_LOWWR_BIT] = lead && prevLowWr && sinceTrail < LOWWR_MIN_TARB;    // [R05]
    setFlags[ST_RBT_BIT]   = lead && cfg[CFG_RBT_BIT];                            // [R01]
    setFlags[ST_DIR_BIT]   = style68 && strobe && strobeQ && capSel && direction != dirQ; // [R11]
    clrFlags = '0;
    if (apbAccess && pwrite && paddr == STATUS_ADDR)
      clrFlags = pwdata[ST_W-1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      status <= ST_RESET;
    else
      status <= (status & ~clrFlags) | setFlags;
  end

  // ----------------------------------------
  // Internal registers and memory
  // ----------------------------------------
  logic dataDone;
  assign dataDone = trail && capAddr == HA_DATA;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr <= '0;
    end else if (trail && !readQ && capAddr == HA_PTR_LOW) begin
      ptr[7:0] <= adIn;                                            // [R09]
    end else if (trail && !readQ && capAddr == HA_PTR_HIGH) begin
      ptr[PTR_W-1:8] <= adIn[PTR_W-9:0];                           // [R09]
    end else if (dataDone) begin
      ptr <= ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (trail && !readQ && capAddr == HA_DATA)
      mem[ptr] <= adIn;                                            // [R09]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++)
        scratch[i] <= 8'h00;
    end else if (trail && !readQ && capAddr <= HA_SCRATCH_TOP) begin
      scratch[capAddr[1:0]] <= adIn;                               // [R09]
    end
  end

  function automatic logic [7:0] host_read(input logic [2:0] a);
    if (a <= HA_SCRATCH_TOP)
      host_read = scratch[a[1:0]];
    else if (a == HA_PTR_LOW)
      host_read = ptr[7:0];
    else if (a == HA_PTR_HIGH)
      host_read = 8'(ptr[PTR_W-1:8]);
    else if (a == HA_DATA)
      host_read = mem[ptr];
    else
      host_read = 8'h00;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adOut <= 8'h00;
      adOe  <= 1'b0;
    end else begin
      if (lead && isRead)
        adOut <= host_read(capAddr);
      adOe <= (lead && isRead) || (adOe && strobe);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg      <= CFG_RESET;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else begin
      pready  <= apbAccess;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apbAccess) begin
        unique case (paddr)
          CONFIG_ADDR: begin
            if (pwrite)
              cfg <= pwdata[CFG_W-1:0];
            prdata <= 32'(cfg);
          end
          STATUS_ADDR:  prdata <= 32'(status);
          CAPTURE_ADDR: prdata <= 32'({sinceTrail, sinceLead, capSel, capAddr});
          POINTER_ADDR: prdata <= 32'(ptr);
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_capture_address: assert property ($fell(addressLatch) |=> capAddr == $past(adIn[2:0])) // [R08]
    else $error("Address not captured on latch fall");
  a_capture_select: assert property ($fell(addressLatch) |=> capSel == !$past(chip_select_n)) // [R08]
    else $error("Chip select not captured on latch fall");
  a_cycle_spacing: assert property (lead && sinceLead < CYCLE_MIN_TARB |=> status[ST_CYCLE_BIT]) // [R02]
    else $error("Short strobe cycle not flagged");
  a_data_pointer: assert property (lead && prevData && ptrTarget && isRead && sinceTrail < DPTR_MIN_TARB
                                   |=> status[ST_DPTR_BIT]) // [R03]
    else $error("Early pointer read not flagged");
  a_low_write_gap: assert property (lead && prevLowWr && sinceTrail < LOWWR_MIN_TARB |=> status[ST_LOWWR_BIT]) // [R05]
    else $error("Early cycle after low pointer write not flagged");
  a_read_timing: assert property (lead && cfg[CFG_RBT_BIT] |=> status[ST_RBT_BIT]) // [R01]
    else $error("Read timing select misuse not flagged");
  a_slow_half: assert property ((cfg[CFG_SLOW_BIT] && arbTick) ##1 cfg[CFG_SLOW_BIT] |-> !arbTick) // [R06]
    else $error("Slow arbitration clock ticks twice in a row");
  a_fast_mult: assert property (!cfg[CFG_SLOW_BIT] && cfg[CFG_MULT1_BIT] |-> arbTick) // [R07]
    else $error("Arbitration tick missing at full rate");
  a_pointer_step: assert property (dataDone |=> ptr == $past(ptr) + 1'b1) // [R12]
    else $error("Pointer did not step after data access");
  a_write_store: assert property (trail && !readQ && capAddr == HA_PTR_LOW |=> ptr[7:0] == $past(adIn)) // [R09]
    else $error("Low pointer not written on trailing edge");
endmodule

// ### verification/host_mcu_model.sv
// Behavioural host on the multiplexed address/data bus.
// Assumes the device samples every host pin on the rising edge of clk.
`timescale 1ns/100ps
module host_mcu_model (
  input  wire logic       clk,
  input  wire logic [7:0] adOut,
  input  wire logic       adOe,
  output logic            addressLatch,
  output logic            chip_select_n,
  output logic            data_strobe_n,
  output logic            direction,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      adIn
);
  logic [7:0] busVal;
  logic       busOn;

  // ----------------------------------------
  // Bus level: device, host, or inverse of last
  // ----------------------------------------
  assign adIn = adOe ? adOut : (busOn ? busVal : ~busVal);

  initial begin
    addressLatch = 1'b0;
    chip_select_n = 1'b1;
    data_strobe_n = 1'b1;
    direction = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    busOn = 1'b0;
    busVal = 8'h00;
  end

  // ----------------------------------------
  // One host cycle: latch, strobe, trailing data
  // ----------------------------------------
  task automatic access(input logic m68, input logic wr, input logic sel, input logic [2:0] a,
                        input logic [7:0] d, input int gap, input int hold, output logic [7:0] q);
    @(posedge clk);
    addressLatch <= 1'b1;
    chip_select_n <= !sel;
    busOn <= 1'b1;
    busVal <= {5'h00, a};
    direction <= !wr;
    @(posedge clk);
    addressLatch <= 1'b0;
    @(posedge clk);
    busOn <= wr;
    busVal <= ~d;
    if (m68) begin
      data_strobe_n <= 1'b0;
    end else if (wr) begin
      write_strobe_n <= 1'b0;
    end else begin
      read_strobe_n <= 1'b0;
    end
    repeat (hold) @(posedge clk);
    q = adIn;
    busVal <= d;
    data_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    @(posedge clk);
    busOn <= 1'b0;
    chip_select_n <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask

  // ----------------------------------------
  // Direction flip inside a strobe, for the awkward case
  // ----------------------------------------
  task automatic flip_dir();
    direction <= !direction;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the multiplexed host bus port.
// Assumes host_mcu_model drives the host pins; APB is driven here.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench
  import host_port_pkg::*;
;
  typedef struct packed {
    logic [4:0] cfg;
    logic [2:0] a1;
    logic [2:0] a2;
    logic [3:0] gap;
    logic [3:0] hold;
    logic [4:0] st;
  } row_t;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        addressLatch, chip_select_n, data_strobe_n, direction, read_strobe_n, write_strobe_n, adOe;
  logic [7:0]  adIn, adOut, q;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [2:0]  pa [7] = '{3'h4, 3'h5, 3'h6, 3'h6, 3'h5, 3'h6, 3'h6};
  logic [7:0]  pd [7] = '{8'h00, 8'h10, 8'h11, 8'h22, 8'h10, 8'h00, 8'h00};
  row_t        rows [10] = '{
    '{5'h00, 3'h0, 3'h1, 4'h4, 4'h3, 5'h01}, '{5'h01, 3'h0, 3'h1, 4'h4, 4'h3, 5'h00},
    '{5'h02, 3'h0, 3'h1, 4'h0, 4'h3, 5'h00}, '{5'h05, 3'h0, 3'h1, 4'h0, 4'h3, 5'h01},
    '{5'h06, 3'h0, 3'h1, 4'h4, 4'h3, 5'h00}, '{5'h02, 3'h6, 3'h5, 4'h0, 4'h3, 5'h02},
    '{5'h02, 3'h6, 3'h5, 4'h2, 4'h3, 5'h00}, '{5'h01, 3'h5, 3'h0, 4'h0, 4'h9, 5'h04},
    '{5'h0A, 3'h0, 3'h1, 4'h8, 4'h3, 5'h08}, '{5'h12, 3'h0, 3'h1, 4'h0, 4'h3, 5'h00}};

  host_bus_access_spacing #(.PTR_W(9)) dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .addressLatch, .chip_select_n, .data_strobe_n, .direction,
    .read_strobe_n, .write_strobe_n, .adIn, .adOut, .adOe);
  host_mcu_model host_u (.clk, .adOut, .adOe, .addressLatch, .chip_select_n, .data_strobe_n,
    .direction, .read_strobe_n, .write_strobe_n, .adIn);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Closing report and APB master
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, CONFIG_ADDR, 32'h0000_0000);
    `CHK("config reset", 32'h0000_0000, rd)
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK("status reset", 32'h0000_0000, rd)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    foreach (rows[i]) begin
      apb(1'b1, CONFIG_ADDR, {27'h0, rows[i].cfg});
      repeat (64) @(posedge clk);
      apb(1'b1, STATUS_ADDR, 32'h0000_001F);
      host_u.access(rows[i].cfg[CFG_STYLE_BIT], 1'b1, 1'b1, rows[i].a1, 8'h3C, rows[i].gap, rows[i].hold, q);
      host_u.access(rows[i].cfg[CFG_STYLE_BIT], 1'b1, 1'b1, rows[i].a2, 8'h00, 0, 3, q);
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      `CHK("spacing flags", {27'h0, rows[i].st}, rd)
    end
    apb(1'b1, CONFIG_ADDR, 32'h0000_0002);
    host_u.access(1'b0, 1'b1, 1'b1, 3'h2, 8'h5A, 10, 3, q);
    host_u.access(1'b0, 1'b1, 1'b0, 3'h2, 8'h00, 10, 3, q);
    host_u.access(1'b0, 1'b0, 1'b1, 3'h2, 8'h00, 10, 3, q);
    `CHK("scratch read", 8'h5A, q)
    apb(1'b1, CONFIG_ADDR, 32'h0000_0012);
    host_u.access(1'b1, 1'b1, 1'b1, 3'h3, 8'hC3, 10, 3, q);
    host_u.access(1'b1, 1'b0, 1'b1, 3'h3, 8'h00, 10, 3, q);
    `CHK("strobe style read", 8'hC3, q)
    apb(1'b1, CONFIG_ADDR, 32'h0000_0002);
    for (int k = 0; k < 7; k++) begin
      host_u.access(1'b0, k < 5, 1'b1, pa[k], pd[k], 10, 3, q);
      if (k > 4) begin
        `CHK("data read", pd[k-3], q)
      end
    end
    apb(1'b0, POINTER_ADDR, 32'h0000_0000);
    `CHK("pointer", 32'h0000_0012, rd)
    apb(1'b0, CAPTURE_ADDR, 32'h0000_0000);
    `CHK("capture", 32'h0000_03FE, rd)
    apb(1'b1, STATUS_ADDR, 32'h0000_001F);
    host_u.access(1'b0, 1'b0, 1'b1, 3'h6, 8'h00, 0, 3, q);
    host_u.access(1'b0, 1'b0, 1'b1, 3'h5, 8'h00, 10, 3, q);
    `CHK("pointer low read", 8'h13, q)
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK("early pointer read", 32'h0000_0002, rd)
    apb(1'b1, CONFIG_ADDR, 32'h0000_0012);
    apb(1'b1, STATUS_ADDR, 32'h0000_001F);
    fork
      host_u.access(1'b1, 1'b1, 1'b1, 3'h1, 8'h77, 10, 3, q);
      begin
        repeat (4) @(posedge clk);
        host_u.flip_dir();
      end
    join
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK("direction change", 32'h0000_0010, rd)
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, CONFIG_ADDR, 32'h0000_0000);
    `CHK("config after reset", 32'h0000_0000, rd)
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    `CHK("status after reset", 32'h0000_0000, rd)
    stop_test();
  end
endmodule
